// ### shared/gpbpi_pkg.sv
// Constants for the GPIO port bank with pin and group interrupts.
// Summary of operation
// - Eight independent ports each hold up to 31 pin bits.
// - Every pin bit has its own direction bit that software may change at any time.
// - Set and clear registers drive written-one bits high or low and leave zero bits alone.
// - One register reads back the output latch and another the live pin levels.
// - After reset every pin is an input with pull-up on and input buffer off.
// - A masked access touches only unmasked bits and leaves masked bits unchanged.
// - Every register accepts byte, half-word and word writes on the right lanes.
// - One write loads the complete output value of a port.
// - Eight interrupt channels each pick any pin and are edge or level sensitive.
// - Two group interrupts fire from any chosen combination of pins in each port.
// - Pins left to this block are driven and sensed under its registers.
// - The registers are reached as a single-transfer bus slave with short latency.
package gpbpi_pkg;
    localparam int NUM_PORTS = 8;
    localparam int PORT_W    = 31;
    localparam int NUM_CH    = 8;
    localparam int NUM_GRP   = 2;
    localparam int ADDR_W    = 10;
    // Region select in address bits 9:8.
    localparam logic [1:0] RGN_PORT = 2'h0;
    localparam logic [1:0] RGN_PINT = 2'h1;
    localparam logic [1:0] RGN_GRP  = 2'h2;
    // Per-port register index in address bits 4:2, port number in bits 7:5.
    localparam logic [2:0] REG_DIR  = 3'h0;
    localparam logic [2:0] REG_MASK = 3'h1;
    localparam logic [2:0] REG_PIN  = 3'h2;
    localparam logic [2:0] REG_MPIN = 3'h3;
    localparam logic [2:0] REG_OUT  = 3'h4;
    localparam logic [2:0] REG_SET  = 3'h5;
    localparam logic [2:0] REG_CLR  = 3'h6;
    localparam logic [2:0] REG_IBUF = 3'h7;
    // Pin interrupt register index in address bits 4:2.
    localparam logic [2:0] PREG_MODE = 3'h0;
    localparam logic [2:0] PREG_RISE = 3'h1;
    localparam logic [2:0] PREG_FALL = 3'h2;
    localparam logic [2:0] PREG_STAT = 3'h3;
    localparam logic [2:0] PREG_SELL = 3'h4;
    localparam logic [2:0] PREG_SELH = 3'h5;
    // Group register index in bits 6:2, group in bit 7.
    localparam logic [4:0] GREG_POL  = 5'h00;
    localparam logic [4:0] GREG_ENA  = 5'h08;
    localparam logic [4:0] GREG_CTRL = 5'h10;
    localparam int CTRL_FLAG = 0;
    localparam int CTRL_AND  = 1;
    // Reset values.
    localparam logic [30:0] RST_DIR_N = 31'h7fffffff;
    localparam logic [30:0] RST_ZERO  = 31'h00000000;
    localparam logic [30:0] RST_PULL  = 31'h7fffffff;
endpackage : gpbpi_pkg

// ### src/gpbpi_top.sv
// GPIO port bank with pin interrupts, group interrupts and a register port.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module gpbpi_top (
    input  wire logic         CLK,
    input  wire logic         RST_N,
    input  wire logic [9:0]   ADDR,
    input  wire logic [31:0]  WDATA,
    input  wire logic [3:0]   BE,
    input  wire logic         WR_EN,
    input  wire logic         RD_EN,
    output logic      [31:0]  RDATA,
    input  wire logic [247:0] PIN_IN,
    output logic      [247:0] PIN_OUT,
    output logic      [247:0] PIN_OE_N,
    output logic      [247:0] PULL_UP,
    output logic      [247:0] INBUF_EN,
    output logic      [7:0]   PINT_REQ,
    output logic      [1:0]   GROUP_REQ
);
    localparam int NP = gpbpi_pkg::NUM_PORTS;
    localparam int PW = gpbpi_pkg::PORT_W;

    // Expands byte enables into a bit mask of written lanes.
    function automatic logic [31:0] lanes(input logic [3:0] be);
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lanes

    // Picks one synchronised pin from a port and pin select byte.
    function automatic logic pick(input logic [247:0] v, input logic [7:0] sel);
        if (sel[4:0] > 5'h1e) begin
            pick = 1'b0;
        end else begin
            pick = v[int'(sel[7:5]) * 31 + int'(sel[4:0])];
        end
    endfunction : pick

    logic [30:0] out_q   [NP];
    logic [30:0] dir_n   [NP];
    logic [30:0] mask_q  [NP];
    logic [30:0] ibuf    [NP];
    logic [30:0] next_out  [NP];
    logic [30:0] next_dirn [NP];
    logic [30:0] next_mask [NP];
    logic [30:0] next_ibuf [NP];
    logic [247:0] sync1;
    logic [247:0] sync2;
    logic [247:0] prev;
    logic [7:0]  mode_lvl, rise_en, fall_en, ist;
    logic [7:0]  next_mode, next_rise, next_fall, next_ist, next_req;
    logic [63:0] sel, next_sel;
    logic [30:0] gpol [2][NP];
    logic [30:0] gena [2][NP];
    logic [30:0] next_gpol [2][NP];
    logic [30:0] next_gena [2][NP];
    logic [1:0]  gand, gflag, ghit_prev, next_gand, next_gflag, ghit;
    logic [31:0] next_rdata;

    logic [1:0]  rgn;
    logic [2:0]  pp;
    logic [2:0]  preg;
    logic [4:0]  greg;
    logic        gsel;
    logic [31:0] lm;
    logic [30:0] wd;
    assign rgn  = ADDR[9:8];
    assign pp   = ADDR[7:5];
    assign preg = ADDR[4:2];
    assign greg = ADDR[6:2];
    assign gsel = ADDR[7];
    assign lm   = lanes(BE);
    assign wd   = WDATA[30:0];

    // Two-stage pin synchroniser, then a history stage for edge detection.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync1 <= '0;
            sync2 <= '0;
            prev  <= '0;
        end else begin
            sync1 <= PIN_IN;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // Port register writes: direction, mask, latch, set, clear, input buffer.
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            next_out[p]  = out_q[p];
            next_dirn[p] = dir_n[p];
            next_mask[p] = mask_q[p];
            next_ibuf[p] = ibuf[p];
        end
        if (WR_EN && rgn == gpbpi_pkg::RGN_PORT) begin
            case (preg)
                gpbpi_pkg::REG_DIR:  next_dirn[pp] = (dir_n[pp] & ~lm[30:0]) | (~wd & lm[30:0]);
                gpbpi_pkg::REG_MASK: next_mask[pp] = (mask_q[pp] & ~lm[30:0]) | (wd & lm[30:0]);
                gpbpi_pkg::REG_MPIN: next_out[pp]  = (out_q[pp] & (mask_q[pp] | ~lm[30:0]))
                                                   | (wd & ~mask_q[pp] & lm[30:0]);
                gpbpi_pkg::REG_OUT:  next_out[pp]  = (out_q[pp] & ~lm[30:0]) | (wd & lm[30:0]);
                gpbpi_pkg::REG_SET:  next_out[pp]  = out_q[pp] | (wd & lm[30:0]);
                gpbpi_pkg::REG_CLR:  next_out[pp]  = out_q[pp] & ~(wd & lm[30:0]);
                gpbpi_pkg::REG_IBUF: next_ibuf[pp] = (ibuf[pp] & ~lm[30:0]) | (wd & lm[30:0]);
                default: ;
            endcase
        end
    end

    // Port registers; all pins start as inputs with pull-ups and buffers off.
    always_ff @(posedge CLK) begin
        for (int p = 0; p < NP; p++) begin
            if (!RST_N) begin
                out_q[p]  <= gpbpi_pkg::RST_ZERO;
                dir_n[p]  <= gpbpi_pkg::RST_DIR_N;
                mask_q[p] <= gpbpi_pkg::RST_ZERO;
                ibuf[p]   <= gpbpi_pkg::RST_ZERO;
            end else begin
                out_q[p]  <= next_out[p];
                dir_n[p]  <= next_dirn[p];
                mask_q[p] <= next_mask[p];
                ibuf[p]   <= next_ibuf[p];
            end
        end
    end

    // Pin drive straight from the registers, pull-ups tied on from a constant.
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            PIN_OUT[p*PW +: PW]  = out_q[p];
            PIN_OE_N[p*PW +: PW] = dir_n[p];
            INBUF_EN[p*PW +: PW] = ibuf[p];
            PULL_UP[p*PW +: PW]  = gpbpi_pkg::RST_PULL;
        end
    end

    // Pin interrupt channels: edge status is sticky, level follows the pin.
    always_comb begin
        logic lvl, pv, rs, fl;
        lvl = 1'b0;
        pv = 1'b0;
        rs = 1'b0;
        fl = 1'b0;
        next_mode = mode_lvl;
        next_rise = rise_en;
        next_fall = fall_en;
        next_sel  = sel;
        if (WR_EN && rgn == gpbpi_pkg::RGN_PINT) begin
            case (preg)
                gpbpi_pkg::PREG_MODE: next_mode = BE[0] ? WDATA[7:0] : mode_lvl;
                gpbpi_pkg::PREG_RISE: next_rise = BE[0] ? WDATA[7:0] : rise_en;
                gpbpi_pkg::PREG_FALL: next_fall = BE[0] ? WDATA[7:0] : fall_en;
                gpbpi_pkg::PREG_SELL: next_sel[31:0]  = (sel[31:0] & ~lm) | (WDATA & lm);
                gpbpi_pkg::PREG_SELH: next_sel[63:32] = (sel[63:32] & ~lm) | (WDATA & lm);
                default: ;
            endcase
        end
        for (int c = 0; c < gpbpi_pkg::NUM_CH; c++) begin
            lvl = pick(sync2, sel[c*8 +: 8]);
            pv  = pick(prev, sel[c*8 +: 8]);
            rs  = rise_en[c] & lvl & ~pv;
            fl  = fall_en[c] & ~lvl & pv;
            if (mode_lvl[c]) begin
                next_ist[c] = rise_en[c] & (lvl == fall_en[c]);
            end else begin
                // A new edge in the clearing cycle wins over the clear.
                next_ist[c] = (ist[c] & ~(WR_EN && rgn == gpbpi_pkg::RGN_PINT
                              && preg == gpbpi_pkg::PREG_STAT && BE[0] && WDATA[c]))
                              | rs | fl;
            end
            next_req[c] = next_ist[c];
        end
    end

    // Pin interrupt registers.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mode_lvl <= '0;
            rise_en  <= '0;
            fall_en  <= '0;
            ist      <= '0;
            sel      <= '0;
            PINT_REQ <= '0;
        end else begin
            mode_lvl <= next_mode;
            rise_en  <= next_rise;
            fall_en  <= next_fall;
            ist      <= next_ist;
            sel      <= next_sel;
            PINT_REQ <= next_req;
        end
    end

    // Group interrupts: match enabled pins against polarity, OR or AND combine.
    always_comb begin
        logic any, all, en;
        logic [30:0] hit;
        any = 1'b0;
        all = 1'b1;
        en = 1'b0;
        hit = '0;
        next_gand = gand;
        for (int g = 0; g < 2; g++) begin
            for (int p = 0; p < NP; p++) begin
                next_gpol[g][p] = gpol[g][p];
                next_gena[g][p] = gena[g][p];
            end
        end
        if (WR_EN && rgn == gpbpi_pkg::RGN_GRP) begin
            if (greg < gpbpi_pkg::GREG_ENA) begin
                next_gpol[gsel][greg[2:0]] = (gpol[gsel][greg[2:0]] & ~lm[30:0]) | (wd & lm[30:0]);
            end else if (greg < gpbpi_pkg::GREG_CTRL) begin
                next_gena[gsel][greg[2:0]] = (gena[gsel][greg[2:0]] & ~lm[30:0]) | (wd & lm[30:0]);
            end else if (greg == gpbpi_pkg::GREG_CTRL && BE[0]) begin
                next_gand[gsel] = WDATA[gpbpi_pkg::CTRL_AND];
            end
        end
        for (int g = 0; g < 2; g++) begin
            any = 1'b0;
            all = 1'b1;
            en  = 1'b0;
            for (int p = 0; p < NP; p++) begin
                hit = gena[g][p] & ~(sync2[p*PW +: PW] ^ gpol[g][p]);
                any = any | (|hit);
                all = all & (&(hit | ~gena[g][p]));
                en  = en | (|gena[g][p]);
            end
            ghit[g] = gand[g] ? (all & en) : any;
            next_gflag[g] = (gflag[g] & ~(WR_EN && rgn == gpbpi_pkg::RGN_GRP && gsel == g[0]
                            && greg == gpbpi_pkg::GREG_CTRL && BE[0]
                            && WDATA[gpbpi_pkg::CTRL_FLAG])) | (ghit[g] & ~ghit_prev[g]);
        end
    end

    // Group registers and request outputs.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int g = 0; g < 2; g++) begin
                for (int p = 0; p < NP; p++) begin
                    gpol[g][p] <= gpbpi_pkg::RST_ZERO;
                    gena[g][p] <= gpbpi_pkg::RST_ZERO;
                end
            end
            gand      <= '0;
            gflag     <= '0;
            ghit_prev <= '0;
            GROUP_REQ <= '0;
        end else begin
            gpol      <= next_gpol;
            gena      <= next_gena;
            gand      <= next_gand;
            gflag     <= next_gflag;
            ghit_prev <= ghit;
            GROUP_REQ <= next_gflag;
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads give zero.
    always_comb begin
        next_rdata = '0;
        if (RD_EN) begin
            case (rgn)
                gpbpi_pkg::RGN_PORT: begin
                    case (preg)
                        gpbpi_pkg::REG_DIR:  next_rdata = {1'b0, ~dir_n[pp]};
                        gpbpi_pkg::REG_MASK: next_rdata = {1'b0, mask_q[pp]};
                        gpbpi_pkg::REG_PIN:  next_rdata = {1'b0, sync2[pp*PW +: PW]};
                        gpbpi_pkg::REG_MPIN: next_rdata = {1'b0, sync2[pp*PW +: PW] & ~mask_q[pp]};
                        gpbpi_pkg::REG_OUT:  next_rdata = {1'b0, out_q[pp]};
                        gpbpi_pkg::REG_SET:  next_rdata = {1'b0, out_q[pp]};
                        gpbpi_pkg::REG_IBUF: next_rdata = {1'b0, ibuf[pp]};
                        default:             next_rdata = '0;
                    endcase
                end
                gpbpi_pkg::RGN_PINT: begin
                    case (preg)
                        gpbpi_pkg::PREG_MODE: next_rdata = {24'h000000, mode_lvl};
                        gpbpi_pkg::PREG_RISE: next_rdata = {24'h000000, rise_en};
                        gpbpi_pkg::PREG_FALL: next_rdata = {24'h000000, fall_en};
                        gpbpi_pkg::PREG_STAT: next_rdata = {24'h000000, ist};
                        gpbpi_pkg::PREG_SELL: next_rdata = sel[31:0];
                        gpbpi_pkg::PREG_SELH: next_rdata = sel[63:32];
                        default:              next_rdata = '0;
                    endcase
                end
                gpbpi_pkg::RGN_GRP: begin
                    if (greg < gpbpi_pkg::GREG_ENA) begin
                        next_rdata = {1'b0, gpol[gsel][greg[2:0]]};
                    end else if (greg < gpbpi_pkg::GREG_CTRL) begin
                        next_rdata = {1'b0, gena[gsel][greg[2:0]]};
                    end else if (greg == gpbpi_pkg::GREG_CTRL) begin
                        next_rdata = {30'h00000000, gand[gsel], gflag[gsel]};
                    end
                end
                default: next_rdata = '0;
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RDATA <= '0;
        end else begin
            RDATA <= next_rdata;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Checks on reset, port zero and port three behaviour, synchroniser and interrupt timing.
    sequence s_set0;
        WR_EN && ADDR == {2'h0, 3'h0, gpbpi_pkg::REG_SET, 2'h0} && BE == 4'hf;
    endsequence
    sequence s_clr0;
        WR_EN && ADDR == {2'h0, 3'h0, gpbpi_pkg::REG_CLR, 2'h0} && BE == 4'hf;
    endsequence
    property p_reset_input;
        $past(!RST_N) |-> PIN_OE_N == '1 && INBUF_EN == '0 && PULL_UP == '1;
    endproperty
    a_reset_input: assert property (@(posedge CLK) disable iff (1'b0) p_reset_input)
        else $error("Pins not inputs after reset.");
    property p_set;
        s_set0 |=> (PIN_OUT[30:0] & $past(WDATA[30:0])) == $past(WDATA[30:0]);
    endproperty
    a_set: assert property (p_set) else $error("Set write did not raise bits.");
    property p_clr;
        s_clr0 |=> (PIN_OUT[30:0] & $past(WDATA[30:0])) == 31'h00000000
                   && (PIN_OUT[30:0] & ~$past(WDATA[30:0])) == $past(PIN_OUT[30:0] & ~WDATA[30:0]);
    endproperty
    a_clr: assert property (p_clr) else $error("Clear write wrong.");
    property p_dir;
        WR_EN && ADDR == 10'h000 && BE == 4'hf |=> PIN_OE_N[30:0] == ~$past(WDATA[30:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("Direction write wrong.");
    property p_mask;
        WR_EN && ADDR == {2'h0, 3'h3, gpbpi_pkg::REG_MPIN, 2'h0}
        |=> (PIN_OUT[93 +: 31] & mask_q[3]) == ($past(PIN_OUT[93 +: 31]) & mask_q[3]);
    endproperty
    a_mask: assert property (p_mask) else $error("Masked bits changed.");
    property p_byte;
        WR_EN && ADDR == {2'h0, 3'h0, gpbpi_pkg::REG_OUT, 2'h0} && BE == 4'h2
        |=> PIN_OUT[30:16] == $past(PIN_OUT[30:16]) && PIN_OUT[7:0] == $past(PIN_OUT[7:0])
            && PIN_OUT[15:8] == $past(WDATA[15:8]);
    endproperty
    a_byte: assert property (p_byte) else $error("Byte lane write wrong.");
    property p_readback;
        RD_EN && ADDR == {2'h0, 3'h0, gpbpi_pkg::REG_OUT, 2'h0} ##1 !$past(WR_EN)
        |-> RDATA == {1'b0, $past(PIN_OUT[30:0])};
    endproperty
    a_readback: assert property (p_readback) else $error("Latch readback wrong.");
    property p_sync;
        RST_N [*3] |-> sync2 == $past(PIN_IN, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("Synchroniser depth wrong.");
    property p_edge;
        !mode_lvl[0] && rise_en[0] && pick(sync2, sel[7:0]) && !pick(prev, sel[7:0])
        |=> ist[0] ##1 PINT_REQ[0];
    endproperty
    a_edge: assert property (p_edge) else $error("Rising edge not flagged.");
    property p_group;
        ghit[0] && !ghit_prev[0] |=> gflag[0] && GROUP_REQ[0];
    endproperty
    a_group: assert property (p_group) else $error("Group request missing.");
endmodule : gpbpi_top

// ### verification/gpbpi_pad_model.sv
// Board-side pad model that resolves each pin from the block, a test driver and the pull-up.
`timescale 1ns/1ps
module gpbpi_pad_model (
    input  wire logic         clk,
    input  wire logic [247:0] pin_out,
    input  wire logic [247:0] pin_oe_n,
    input  wire logic [247:0] pull_up,
    input  wire logic [247:0] ext_en,
    input  wire logic [247:0] ext_val,
    output logic      [247:0] pin_in
);
    logic [247:0] last;

    // The block wins when it drives, then the test driver, then the pull-up.
    // A pad with nothing on it shows the inverse of its last level, never a stale value.
    assign pin_in = (~pin_oe_n & pin_out)
                  | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en & pull_up)
                  | (pin_oe_n & ~ext_en & ~pull_up & ~last);

    // Remembers the last resolved level of every pad.
    always_ff @(posedge clk) begin
        last <= pin_in;
    end
endmodule : gpbpi_pad_model

// ### verification/gpbpi_top_tb.sv
// Self-checking bench for the GPIO port bank: registers, pins and interrupts.
`timescale 1ns/1ps
module gpbpi_top_tb;
    typedef struct packed {
        logic [9:0]  wa;
        logic [31:0] wd;
        logic [3:0]  be;
        logic [9:0]  ra;
        logic [31:0] ex;
    } gpbpi_row_t;

    logic         clk;
    logic         rst_n;
    logic [9:0]   addr;
    logic [31:0]  wdata;
    logic [3:0]   be;
    logic         wr_en;
    logic         rd_en;
    logic [31:0]  rdata;
    logic [247:0] pin_in;
    logic [247:0] pin_out;
    logic [247:0] pin_oe_n;
    logic [247:0] pull_up;
    logic [247:0] inbuf_en;
    logic [7:0]   pint_req;
    logic [1:0]   group_req;
    logic [247:0] ext_en;
    logic [247:0] ext_val;
    logic [9:0]   irq_all;
    int           err_total;
    int           n_tests;

    // Address builders for port, pin interrupt and group registers.
    function automatic logic [9:0] pa(input int p, input logic [2:0] r);
        return {gpbpi_pkg::RGN_PORT, 3'(p), r, 2'h0};
    endfunction : pa
    function automatic logic [9:0] ia(input logic [2:0] r);
        return {gpbpi_pkg::RGN_PINT, 3'h0, r, 2'h0};
    endfunction : ia
    function automatic logic [9:0] ga(input int g, input logic [4:0] r);
        return {gpbpi_pkg::RGN_GRP, 1'(g), r, 2'h0};
    endfunction : ga

    // Each row is a write followed by a read and the word that read must return.
    localparam gpbpi_row_t rows [12] = '{
        '{pa(0, gpbpi_pkg::REG_OUT), 32'hffffffff, 4'hf, pa(0, gpbpi_pkg::REG_OUT), 32'h7fffffff},
        '{pa(0, gpbpi_pkg::REG_OUT), 32'h0000aa00, 4'h2, pa(0, gpbpi_pkg::REG_OUT), 32'h7fffaaff},
        '{pa(0, gpbpi_pkg::REG_CLR), 32'h000000f0, 4'hf, pa(0, gpbpi_pkg::REG_OUT), 32'h7fffaa0f},
        '{pa(0, gpbpi_pkg::REG_SET), 32'h00000100, 4'hf, pa(0, gpbpi_pkg::REG_OUT), 32'h7fffab0f},
        '{pa(0, gpbpi_pkg::REG_CLR), 32'h80000000, 4'hf, pa(0, gpbpi_pkg::REG_CLR), 32'h00000000},
        '{pa(3, gpbpi_pkg::REG_MASK), 32'h0000ffff, 4'hf, pa(3, gpbpi_pkg::REG_MASK), 32'h0000ffff},
        '{pa(3, gpbpi_pkg::REG_MPIN), 32'h12345678, 4'hf, pa(3, gpbpi_pkg::REG_OUT), 32'h12340000},
        '{pa(7, gpbpi_pkg::REG_DIR), 32'h0000a5a5, 4'h3, pa(7, gpbpi_pkg::REG_DIR), 32'h0000a5a5},
        '{pa(7, gpbpi_pkg::REG_DIR), 32'h5a000000, 4'h8, pa(7, gpbpi_pkg::REG_DIR), 32'h5a00a5a5},
        '{pa(0, gpbpi_pkg::REG_DIR), 32'h00000f0f, 4'hf, pa(0, gpbpi_pkg::REG_DIR), 32'h00000f0f},
        '{10'h3f0, 32'hffffffff, 4'hf, 10'h3f0, 32'h00000000},
        '{pa(5, gpbpi_pkg::REG_PIN), 32'hffffffff, 4'hf, pa(5, gpbpi_pkg::REG_OUT), 32'h00000000}
    };

    assign irq_all = {group_req, pint_req};

    gpbpi_top u_gpbpi_top (
        .CLK       (clk),
        .RST_N     (rst_n),
        .ADDR      (addr),
        .WDATA     (wdata),
        .BE        (be),
        .WR_EN     (wr_en),
        .RD_EN     (rd_en),
        .RDATA     (rdata),
        .PIN_IN    (pin_in),
        .PIN_OUT   (pin_out),
        .PIN_OE_N  (pin_oe_n),
        .PULL_UP   (pull_up),
        .INBUF_EN  (inbuf_en),
        .PINT_REQ  (pint_req),
        .GROUP_REQ (group_req)
    );

    gpbpi_pad_model u_gpbpi_pad_model (
        .clk      (clk),
        .pin_out  (pin_out),
        .pin_oe_n (pin_oe_n),
        .pull_up  (pull_up),
        .ext_en   (ext_en),
        .ext_val  (ext_val),
        .pin_in   (pin_in)
    );

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle register write.
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        be    <= b;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask : wr

    // One-cycle register read; the data is only valid in the following cycle.
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask : rd

    // Drives or releases one pad from the board side.
    task automatic pin(input int idx, input logic en, input logic v);
        @(posedge clk);
        ext_en[idx]  <= en;
        ext_val[idx] <= v;
    endtask : pin

    // Waits a bounded time for a request line; running out ends the run.
    task automatic wait_irq(input int i, input logic v);
        int k;
        for (k = 0; k < 20 && irq_all[i] !== v; k++) begin
            @(posedge clk);
            #1;
        end
        chk(32'(irq_all[i]), 32'(v));
        if (irq_all[i] !== v) begin
            complete_run();
        end
    endtask : wait_irq

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // Main sequence: reset, register table, pins, pin and group interrupts, second reset.
    initial begin
        rst_n = 1'h0;
        addr = 10'h0;
        wdata = 32'h0;
        be = 4'h0;
        wr_en = 1'h0;
        rd_en = 1'h0;
        ext_en = 248'h0;
        ext_val = 248'h0;
        err_total = 0;
        n_tests = 0;
        repeat (11) @(posedge clk);
        #1;
        chk(32'(pin_oe_n === {248{1'h1}}), 32'h1);
        chk(32'(pull_up === {248{1'h1}}), 32'h1);
        chk(32'(inbuf_en === 248'h0), 32'h1);
        chk(32'(pin_out === 248'h0), 32'h1);
        chk({22'h0, irq_all}, 32'h0);
        @(posedge clk);
        rst_n <= 1'h1;
        rd(pa(0, gpbpi_pkg::REG_DIR), 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd, rows[i].be);
            rd(rows[i].ra, rows[i].ex);
        end
        chk(32'(pin_oe_n[7*31 +: 31]), 32'h25ff5a5a);
        chk(32'(pin_out[0 +: 31]), 32'h7fffab0f);
        for (int p = 0; p < 8; p++) begin
            wr(pa(p, gpbpi_pkg::REG_OUT), 32'h11111111 * 32'(p + 1), 4'hf);
            #1;
            chk(32'(pin_out[p*31 +: 31]), (32'h11111111 * 32'(p + 1)) & 32'h7fffffff);
        end
        // Port 1 mixes driven, board-driven and pulled-up pins.
        wr(pa(1, gpbpi_pkg::REG_IBUF), 32'h7fffffff, 4'hf);
        #1;
        chk(32'(inbuf_en[31 +: 31]), 32'h7fffffff);
        wr(pa(1, gpbpi_pkg::REG_DIR), 32'h3, 4'hf);
        wr(pa(1, gpbpi_pkg::REG_OUT), 32'h1, 4'hf);
        pin(33, 1'h1, 1'h0);
        repeat (4) @(posedge clk);
        rd(pa(1, gpbpi_pkg::REG_PIN), 32'h7ffffff9);
        wr(pa(1, gpbpi_pkg::REG_MASK), 32'h7ffffff0, 4'hf);
        rd(pa(1, gpbpi_pkg::REG_MPIN), 32'h9);
        // Channel 0 rising edge on port 1 pin 3, channel 5 active-low level on pin 4.
        wr(ia(gpbpi_pkg::PREG_SELL), 32'hffffff23, 4'hf);
        wr(ia(gpbpi_pkg::PREG_SELH), 32'hffff24ff, 4'hf);
        wr(ia(gpbpi_pkg::PREG_MODE), 32'h20, 4'hf);
        wr(ia(gpbpi_pkg::PREG_RISE), 32'h21, 4'hf);
        wr(ia(gpbpi_pkg::PREG_FALL), 32'h0, 4'hf);
        wr(ia(gpbpi_pkg::PREG_STAT), 32'hff, 4'hf);
        repeat (4) @(posedge clk);
        chk(32'(pint_req), 32'h0);
        pin(34, 1'h1, 1'h0);
        repeat (5) @(posedge clk);
        chk(32'(pint_req), 32'h0);
        pin(34, 1'h1, 1'h1);
        wait_irq(0, 1'h1);
        rd(ia(gpbpi_pkg::PREG_STAT), 32'h1);
        wr(ia(gpbpi_pkg::PREG_STAT), 32'h1, 4'hf);
        wait_irq(0, 1'h0);
        // Channel 0 also flags falling edges once they are enabled.
        wr(ia(gpbpi_pkg::PREG_FALL), 32'h1, 4'hf);
        pin(34, 1'h1, 1'h0);
        wait_irq(0, 1'h1);
        pin(35, 1'h1, 1'h0);
        wait_irq(5, 1'h1);
        pin(35, 1'h0, 1'h0);
        wait_irq(5, 1'h0);
        // Group 0 in OR mode on port 2 pin 0 low, group 1 in AND mode on pins 0 and 1 low.
        wr(ga(0, 5'(gpbpi_pkg::GREG_POL + 5'h02)), 32'h0, 4'hf);
        wr(ga(0, 5'(gpbpi_pkg::GREG_ENA + 5'h02)), 32'h1, 4'hf);
        wr(ga(0, gpbpi_pkg::GREG_CTRL), 32'h1, 4'hf);
        pin(62, 1'h1, 1'h0);
        wait_irq(8, 1'h1);
        rd(ga(0, gpbpi_pkg::GREG_CTRL), 32'h1);
        wr(ga(0, gpbpi_pkg::GREG_CTRL), 32'h1, 4'hf);
        wait_irq(8, 1'h0);
        wr(ga(1, 5'(gpbpi_pkg::GREG_POL + 5'h02)), 32'h0, 4'hf);
        wr(ga(1, 5'(gpbpi_pkg::GREG_ENA + 5'h02)), 32'h3, 4'hf);
        wr(ga(1, gpbpi_pkg::GREG_CTRL), 32'h3, 4'hf);
        repeat (5) @(posedge clk);
        chk(32'(irq_all[9]), 32'h0);
        pin(63, 1'h1, 1'h0);
        wait_irq(9, 1'h1);
        // A reset in mid-run returns every output to its idle state.
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
        chk({22'h0, irq_all}, 32'h0);
        chk(32'(pin_out === 248'h0), 32'h1);
        chk(32'(pin_oe_n === {248{1'h1}}), 32'h1);
        @(posedge clk);
        rst_n <= 1'h1;
        rd(pa(1, gpbpi_pkg::REG_DIR), 32'h0);
        complete_run();
    end
endmodule : gpbpi_top_tb
